// ### ssrp_top.sv
`timescale 1ns/100ps
`default_nettype none
module ssrp_top (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   wr_n_i,
  input  wire logic [4:0]             reg_addr_bus_i,
  input  wire logic [11:0]            reg_data_i,
  output logic [11:0]                 reg_data_o,
  output logic                        reg_data_oe_o,
  input  wire logic                   master_mode_i,
  input  wire logic                   sync_pulse_i,
  input  wire ssrp_pkg::ssrp_mirror_t ctl_pins_i,
  output ssrp_pkg::ssrp_mirror_t      ctl_eff_o,
  output logic [11:0]                 ctl0_o,
  output logic                        rolling_holdoff_enable_o,
  output logic                        aux_bypass_o,
  output logic                        aux_sel_o,
  output logic [11:0]                 row_o,
  output logic [11:0]                 col_o,
  output logic                        pix_active_o,
  output logic                        pix_valid_o,
  output logic                        halted_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ssrp_pkg::ssrp_bus_t    bus_s1_ff;
  ssrp_pkg::ssrp_bus_t    bus_s2_ff;
  ssrp_pkg::ssrp_bus_t    bus_s3_ff;
  ssrp_pkg::ssrp_mirror_t pins_s1_ff;
  ssrp_pkg::ssrp_mirror_t pins_s2_ff;
  logic                   master_s1_ff;
  logic                   master_s2_ff;
  logic                   sync_s1_ff;
  logic                   sync_s2_ff;

  // One clock only, so strobe edges are found after the sync stages;
  // the host's one-clock minimum pulse width keeps each edge visible.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bus_s1_ff    <= '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 12'h000};
      bus_s2_ff    <= '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 12'h000};
      bus_s3_ff    <= '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 12'h000};
      pins_s1_ff   <= '0;
      pins_s2_ff   <= '0;
      master_s1_ff <= 1'b0;
      master_s2_ff <= 1'b0;
      sync_s1_ff   <= 1'b0;
      sync_s2_ff   <= 1'b0;
    end else begin
      bus_s1_ff    <= '{cs_n: cs_n_i, wr_n: wr_n_i, addr: reg_addr_bus_i,
                        data: reg_data_i};
      bus_s2_ff    <= bus_s1_ff;
      bus_s3_ff    <= bus_s2_ff;
      pins_s1_ff   <= ctl_pins_i;
      pins_s2_ff   <= pins_s1_ff;
      master_s1_ff <= master_mode_i;
      master_s2_ff <= master_s1_ff;
      sync_s1_ff   <= sync_pulse_i;
      sync_s2_ff   <= sync_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  logic cs_fall;
  logic cs_rise;
  logic wr_stb;
  logic rd_stb;

  assign cs_fall = bus_s3_ff.cs_n && !bus_s2_ff.cs_n; // R7
  assign cs_rise = !bus_s3_ff.cs_n && bus_s2_ff.cs_n; // R7
  // Write level is stable while selected, so the last low sample serves
  assign wr_stb  = cs_rise && !bus_s3_ff.wr_n && master_s2_ff; // R11 R9 R8
  assign rd_stb  = cs_fall && bus_s2_ff.wr_n && master_s2_ff; // R12 R9

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [11:0] regs_ff [ssrp_pkg::NUM_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < ssrp_pkg::NUM_REGS; gi++) begin : g_reg
      localparam logic [4:0]  IDX = 5'(gi);
      localparam logic [11:0] RST =
        (IDX == ssrp_pkg::OFS_CTL0) ? ssrp_pkg::CTL0_RST :
        (IDX == ssrp_pkg::OFS_CTL1) ? ssrp_pkg::CTL1_RST :
        ssrp_pkg::OTHER_RST;
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          regs_ff[gi] <= RST; // R3 R4
        end else if (wr_stb && bus_s3_ff.addr == IDX) begin
          regs_ff[gi] <= bus_s3_ff.data; // R11
        end
      end
    end
  endgenerate

  function automatic logic [11:0] rd_word(input logic [4:0] a);
    logic [11:0] w;
    w = 12'h000;
    if (a == ssrp_pkg::OFS_CTL1) begin
      // Stored low bits are never shown; revision is fixed
      w = {regs_ff[ssrp_pkg::OFS_CTL1][11:5], ssrp_pkg::REV_CODE}; // R2
    end else if (a < 5'(ssrp_pkg::NUM_REGS)) begin
      w = regs_ff[a];
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_data_o    <= 12'h000;
      reg_data_oe_o <= 1'b0;
    end else if (!master_s2_ff || cs_rise) begin
      reg_data_oe_o <= 1'b0; // R20 R13
    end else if (rd_stb) begin
      reg_data_o    <= rd_word(bus_s2_ff.addr); // R12
      reg_data_oe_o <= 1'b1; // R13
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  logic [11:0] ctl0_w;
  logic [11:0] ctl1_w;

  assign ctl0_w = regs_ff[ssrp_pkg::OFS_CTL0];
  assign ctl1_w = regs_ff[ssrp_pkg::OFS_CTL1];

  // Pause is the lowest mirror bit but the first struct field
  logic [4:0] mir_w;
  genvar gm;
  generate
    for (gm = 0; gm <= ssrp_pkg::CTL1_MIR_MSB - ssrp_pkg::CTL1_MIR_LSB;
         gm++) begin : g_mir
      assign mir_w[4 - gm] = ctl1_w[ssrp_pkg::CTL1_MIR_LSB + gm]; // R5
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_eff_o                <= '0;
      ctl0_o                   <= ssrp_pkg::CTL0_RST;
      rolling_holdoff_enable_o <= 1'b0;
      aux_bypass_o             <= 1'b1;
    end else begin
      ctl_eff_o <= master_s2_ff ? ssrp_pkg::ssrp_mirror_t'(mir_w) :
        pins_s2_ff; // R5
      ctl0_o                   <= ctl0_w;
      rolling_holdoff_enable_o <= ctl1_w[ssrp_pkg::CTL1_RSH_BIT]; // R3
      aux_bypass_o             <= ctl1_w[ssrp_pkg::CTL1_AUX_BIT]; // R4
    end
  end

  // ----------------------------------------------------------------
  // Region readout
  // ----------------------------------------------------------------
  ssrp_pkg::ssrp_roi_t roi0;
  ssrp_pkg::ssrp_roi_t roi1;
  logic                last_pix;

  assign roi0 = '{
    row_start: regs_ff[ssrp_pkg::OFS_ROI0 + ssrp_pkg::ROI_ROW_START],
    row_stop:  regs_ff[ssrp_pkg::OFS_ROI0 + ssrp_pkg::ROI_ROW_STOP],
    col_start: regs_ff[ssrp_pkg::OFS_ROI0 + ssrp_pkg::ROI_COL_START],
    col_stop:  regs_ff[ssrp_pkg::OFS_ROI0 + ssrp_pkg::ROI_COL_STOP]};
  assign roi1 = '{
    row_start: regs_ff[ssrp_pkg::OFS_ROI1 + ssrp_pkg::ROI_ROW_START],
    row_stop:  regs_ff[ssrp_pkg::OFS_ROI1 + ssrp_pkg::ROI_ROW_STOP],
    col_start: regs_ff[ssrp_pkg::OFS_ROI1 + ssrp_pkg::ROI_COL_START],
    col_stop:  regs_ff[ssrp_pkg::OFS_ROI1 + ssrp_pkg::ROI_COL_STOP]};

  ssrp_roi_seq u_seq (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .run_i      (ctl0_w[ssrp_pkg::CTL0_STOP_N_BIT]), // R1
    .sync_en_i  (ctl0_w[ssrp_pkg::CTL0_SYNC_BIT]), // R19
    .sync_i     (sync_s2_ff),
    .pause_i    (ctl_eff_o.pause),
    .roi0_i     (roi0),
    .roi1_i     (roi1),
    .row_o      (row_o),
    .col_o      (col_o),
    .active_o   (pix_active_o),
    .valid_o    (pix_valid_o),
    .last_pix_o (last_pix),
    .halted_o   (halted_o)
  );

  // Auxiliary sample takes the slot after the final pixel of the frame
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aux_sel_o <= 1'b0;
    end else begin
      aux_sel_o <= 1'b0;
      if (last_pix && aux_bypass_o) begin
        aux_sel_o <= 1'b1; // R4
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_write_commit: assert property ( // R11
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_stb && bus_s3_ff.addr == ssrp_pkg::OFS_CTL0
    |=> ##1 ctl0_o == $past(bus_s3_ff.data, 2))
    else $error("control zero write not committed");
  a_read_drive: assert property ( // R12
    @(posedge clk_sys_i) disable iff (rst_i)
    rd_stb |=> reg_data_oe_o)
    else $error("read did not drive data bus");
  a_read_hold: assert property ( // R13
    @(posedge clk_sys_i) disable iff (rst_i)
    reg_data_oe_o && !cs_rise && master_s2_ff
    |=> $stable(reg_data_o) && reg_data_oe_o)
    else $error("read data changed while selected");
  a_release_bus: assert property ( // R20
    @(posedge clk_sys_i) disable iff (rst_i)
    cs_rise || !master_s2_ff |=> !reg_data_oe_o)
    else $error("data bus still driven");
  a_slave_ignore: assert property ( // R9
    @(posedge clk_sys_i) disable iff (rst_i)
    !master_s2_ff |=> ##1 $stable(ctl0_o))
    else $error("register changed outside master mode");
  a_rev_fixed: assert property ( // R2
    @(posedge clk_sys_i) disable iff (rst_i)
    rd_stb && bus_s2_ff.addr == ssrp_pkg::OFS_CTL1
    |=> reg_data_o[4:0] == ssrp_pkg::REV_CODE)
    else $error("revision code not read back");
  a_mirror_sel: assert property ( // R5
    @(posedge clk_sys_i) disable iff (rst_i)
    !master_s2_ff |=> ctl_eff_o == $past(pins_s2_ff))
    else $error("pins do not govern in slave mode");
  a_holdoff_out: assert property ( // R3
    @(posedge clk_sys_i) disable iff (rst_i)
    ##1 rolling_holdoff_enable_o == $past(ctl1_w[ssrp_pkg::CTL1_RSH_BIT]))
    else $error("holdoff enable does not follow register");
  c_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_stb);
  c_read: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_stb ##[1:20] cs_rise);
endmodule // ssrp_top
`default_nettype wire

// ### ssrp_pkg.sv
// Operation
// R1: Stop bit low halts after current readout
// R2: Revision code in control one is read-only
// R3: Control one bit 5 enables rolling holdoff
// R4: Bit 6 substitutes auxiliary input for last pixel; here aux_sel_o marks the slot after the final pixel instead
// R5: Bits 7-11 mirror pins in master mode
// R6: Second region rows shared with first invalid
// R7: Register access follows strobe edges only
// R8: Host keeps write strobe steady while selected
// R9: Register access only in master mode
// R10: Host strobe pulses last one master clock
// R11: Chip select rise with write low writes
// R12: Chip select fall with write high reads
// R13: Read data driven until chip select rises
// R14: Host addresses registers 0 to 15 hex; the map here ends at 14 hex
// R15: Host drives twelve data bits on writes
// R16: Host holds address, data around strobe edge
// R17: Regions read in programmed order, retrace only
// R18: Zero row stop ends region readout
// R19: Sync bit makes sequencer await sync pulse
// R20: Bus undriven and strobes ignored outside master
package ssrp_pkg;
  // ----------------------------------------------------------------
  // Widths and map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned DATA_W   = 12;
  localparam int unsigned NUM_REGS = 21;
  localparam logic [4:0] OFS_ROI0     = 5'h00;
  localparam logic [4:0] OFS_ROI1     = 5'h04;
  localparam logic [4:0] OFS_HOLDOFF  = 5'h10;
  localparam logic [4:0] OFS_TRANSFER = 5'h11;
  localparam logic [4:0] OFS_CTL0     = 5'h12;
  localparam logic [4:0] OFS_CTL1     = 5'h13;
  localparam logic [4:0] OFS_ROLL     = 5'h14;
  // Field order inside a region block
  localparam logic [4:0] ROI_ROW_START = 5'h00;
  localparam logic [4:0] ROI_ROW_STOP  = 5'h01;
  localparam logic [4:0] ROI_COL_START = 5'h02;
  localparam logic [4:0] ROI_COL_STOP  = 5'h03;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL0_SYNC_BIT   = 4;
  localparam int unsigned CTL0_STOP_N_BIT = 11;
  localparam int unsigned CTL1_REV_MSB    = 4;
  localparam int unsigned CTL1_RSH_BIT    = 5;
  localparam int unsigned CTL1_AUX_BIT    = 6;
  localparam int unsigned CTL1_MIR_LSB    = 7;
  localparam int unsigned CTL1_MIR_MSB    = 11;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] CTL0_RST  = 12'h00C;
  localparam logic [11:0] CTL1_RST  = 12'h040;
  localparam logic [11:0] OTHER_RST = 12'h000;
  // Arbitrary revision value
  localparam logic [4:0]  REV_CODE  = 5'h0A;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cs_n;
    logic        wr_n;
    logic [4:0]  addr;
    logic [11:0] data;
  } ssrp_bus_t;
  typedef struct packed {
    logic pause;
    logic row_ctl_hi;
    logic row_ctl_lo;
    logic col_ctl_hi;
    logic col_ctl_lo;
  } ssrp_mirror_t;
  typedef struct packed {
    logic [11:0] row_start;
    logic [11:0] row_stop;
    logic [11:0] col_start;
    logic [11:0] col_stop;
  } ssrp_roi_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_SCAN,
    ST_RETRACE,
    ST_HALT
  } ssrp_state_t;
endpackage

// ### ssrp_roi_seq.sv
`timescale 1ns/100ps
`default_nettype none
module ssrp_roi_seq (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              run_i,
  input  wire logic              sync_en_i,
  input  wire logic              sync_i,
  input  wire logic              pause_i,
  input  wire ssrp_pkg::ssrp_roi_t roi0_i,
  input  wire ssrp_pkg::ssrp_roi_t roi1_i,
  output logic [11:0]            row_o,
  output logic [11:0]            col_o,
  output logic                   active_o,
  output logic                   valid_o,
  output logic                   last_pix_o,
  output logic                   halted_o
);
  ssrp_pkg::ssrp_state_t state_ff;
  logic                  idx_ff;
  logic [11:0]           row_ff;
  logic [11:0]           col_ff;
  ssrp_pkg::ssrp_roi_t   cur;
  logic                  emit;
  logic                  row_end;
  logic                  reg_end;
  logic                  last_reg;

  assign cur      = idx_ff ? roi1_i : roi0_i;
  assign emit     = (state_ff == ssrp_pkg::ST_SCAN) && !pause_i &&
                    (cur.row_stop != 12'h000);
  assign row_end  = (col_ff == cur.col_stop);
  assign reg_end  = row_end && (row_ff == cur.row_stop);
  assign last_reg = idx_ff || (roi1_i.row_stop == 12'h000);

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ssrp_pkg::ST_IDLE;
      idx_ff   <= 1'b0;
      row_ff   <= 12'h000;
      col_ff   <= 12'h000;
    end else begin
      case (state_ff)
        ssrp_pkg::ST_IDLE: begin
          idx_ff   <= 1'b0;
          row_ff   <= roi0_i.row_start;
          col_ff   <= roi0_i.col_start;
          state_ff <= sync_en_i ? ssrp_pkg::ST_SYNC : ssrp_pkg::ST_SCAN; // R19
        end
        ssrp_pkg::ST_SYNC: begin
          if (sync_i) begin
            state_ff <= ssrp_pkg::ST_SCAN; // R19
          end
        end
        ssrp_pkg::ST_SCAN: begin
          if (cur.row_stop == 12'h000) begin
            state_ff <= run_i ? ssrp_pkg::ST_IDLE : ssrp_pkg::ST_HALT; // R18
          end else if (emit) begin
            if (reg_end) begin
              if (last_reg) begin
                state_ff <= run_i ? ssrp_pkg::ST_IDLE : ssrp_pkg::ST_HALT; // R1
              end else begin
                state_ff <= ssrp_pkg::ST_RETRACE; // R17
              end
            end else if (row_end) begin
              col_ff <= cur.col_start;
              row_ff <= row_ff + 12'h001;
            end else begin
              col_ff <= col_ff + 12'h001;
            end
          end
        end
        ssrp_pkg::ST_RETRACE: begin
          // Only the ordinary one-cycle retrace between regions
          idx_ff   <= 1'b1; // R17
          row_ff   <= roi1_i.row_start;
          col_ff   <= roi1_i.col_start;
          state_ff <= ssrp_pkg::ST_SCAN;
        end
        ssrp_pkg::ST_HALT: begin
          if (run_i) begin
            state_ff <= ssrp_pkg::ST_IDLE;
          end
        end
        default: state_ff <= ssrp_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered pixel outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      row_o      <= 12'h000;
      col_o      <= 12'h000;
      active_o   <= 1'b0;
      valid_o    <= 1'b0;
      last_pix_o <= 1'b0;
      halted_o   <= 1'b0;
    end else begin
      row_o      <= row_ff;
      col_o      <= col_ff;
      active_o   <= emit;
      // Rows already read by the first region are spent
      valid_o    <= emit && !(idx_ff && (row_ff >= roi0_i.row_start) &&
                    (row_ff <= roi0_i.row_stop)); // R6
      last_pix_o <= emit && reg_end && last_reg; // R4
      halted_o   <= (state_ff == ssrp_pkg::ST_HALT);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_halt_on_stop: assert property ( // R1
    @(posedge clk_sys_i) disable iff (rst_i)
    emit && reg_end && last_reg && !run_i |=> ##1 halted_o)
    else $error("sequencer did not halt after readout");
  a_zero_stop_end: assert property ( // R18
    @(posedge clk_sys_i) disable iff (rst_i)
    state_ff == ssrp_pkg::ST_SCAN && cur.row_stop == 12'h000
    |=> !active_o ##1 !active_o)
    else $error("readout went on past zero row stop");
  a_sync_wait: assert property ( // R19
    @(posedge clk_sys_i) disable iff (rst_i)
    state_ff == ssrp_pkg::ST_SYNC && !sync_i |=> !active_o ##1 !active_o)
    else $error("sequencer ran without sync pulse");
  a_region_order: assert property ( // R17
    @(posedge clk_sys_i) disable iff (rst_i)
    state_ff == ssrp_pkg::ST_RETRACE |=> state_ff == ssrp_pkg::ST_SCAN
    && idx_ff)
    else $error("second region not next after retrace");
  a_overlap_bad: assert property ( // R6
    @(posedge clk_sys_i) disable iff (rst_i)
    emit && idx_ff && row_ff == roi0_i.row_start |=> !valid_o)
    else $error("shared row of second region marked valid");
  c_two_regions: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state_ff == ssrp_pkg::ST_RETRACE ##1 emit);
  c_halted: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(halted_o));
  c_sync: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state_ff == ssrp_pkg::ST_SYNC ##1 state_ff == ssrp_pkg::ST_SCAN);
endmodule // ssrp_roi_seq
`default_nettype wire

// ### ssrp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssrp_host_model (
  input  wire logic           clk_sys_i,
  input  wire logic [11:0]    dev_data_i,
  input  wire logic           dev_oe_i,
  output ssrp_pkg::ssrp_bus_t bus_o
);
  logic        cs_n = 1'b1;
  logic        wr_n = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [11:0] drv = 12'h000;
  logic        drv_en = 1'b0;
  logic [11:0] flt = 12'hA5A;
  logic [11:0] wire_lvl;
  // ----------------------------------------------------------------
  // Shared data wire
  // ----------------------------------------------------------------
  // Undriven wire toggles so a stale value never looks valid
  assign wire_lvl = dev_oe_i ? dev_data_i : (drv_en ? drv : flt);
  assign bus_o = {cs_n, wr_n, addr, wire_lvl};
  always @(posedge clk_sys_i) flt <= ~wire_lvl;
  // ----------------------------------------------------------------
  // One access
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [4:0] a,
                        input logic [11:0] d, output logic [11:0] q,
                        output logic seen);
    q = 12'h000;
    seen = 1'b0;
    @(posedge clk_sys_i);
    #2;
    wr_n = ~wr;
    addr = a;
    drv = d;
    drv_en = wr;
    @(posedge clk_sys_i);
    #2;
    cs_n = 1'b0;
    // Six cycles low, well above the synchroniser's need
    repeat (6) begin
      @(posedge clk_sys_i);
      if (!wr && !seen && dev_oe_i === 1'b1) begin
        q = wire_lvl;
        seen = 1'b1;
      end
    end
    #2;
    cs_n = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    #2;
    addr = ~addr;
    drv_en = 1'b0;
    wr_n = 1'b1;
  endtask
endmodule // ssrp_host_model
`default_nettype wire

// ### ssrp_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module ssrp_top_test;
  logic                   clk_sys_i, rst_i, master_mode_i, sync_pulse_i;
  ssrp_pkg::ssrp_bus_t    hb;
  ssrp_pkg::ssrp_mirror_t ctl_pins_i, ctl_eff_o;
  logic [11:0]            reg_data_o, ctl0_o, row_o, col_o;
  logic                   reg_data_oe_o, rsh_o, aux_o, aux_sel_o;
  logic                   pix_active_o, pix_valid_o, halted_o;
  integer                 seed = 23;
  int                     n_errors = 0, cmp_count = 0, i, n, n_aux = 0;
  logic [11:0]            mdl [0:31];
  logic [24:0]            got_q[$], exp_q[$];

  ssrp_host_model u_host (.clk_sys_i(clk_sys_i), .dev_data_i(reg_data_o),
    .dev_oe_i(reg_data_oe_o), .bus_o(hb));
  ssrp_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(hb.cs_n),
    .wr_n_i(hb.wr_n), .reg_addr_bus_i(hb.addr), .reg_data_i(hb.data),
    .reg_data_o(reg_data_o), .reg_data_oe_o(reg_data_oe_o),
    .master_mode_i(master_mode_i), .sync_pulse_i(sync_pulse_i),
    .ctl_pins_i(ctl_pins_i), .ctl_eff_o(ctl_eff_o), .ctl0_o(ctl0_o),
    .rolling_holdoff_enable_o(rsh_o), .aux_bypass_o(aux_o),
    .aux_sel_o(aux_sel_o), .row_o(row_o), .col_o(col_o),
    .pix_active_o(pix_active_o), .pix_valid_o(pix_valid_o),
    .halted_o(halted_o));
  // ----------------------------------------------------------------
  // Checks and model
  // ----------------------------------------------------------------
  task automatic chk12(input logic [11:0] g, e, input string w);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic chk1(input logic g, e, input string w);
    chk12({11'h000, g}, {11'h000, e}, w);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [11:0] exp_rd(input logic [4:0] a);
    if (a > 5'h14) return 12'h000;
    if (a == ssrp_pkg::OFS_CTL1) return {mdl[a][11:5], ssrp_pkg::REV_CODE};
    return mdl[a];
  endfunction
  task automatic wr(input logic [4:0] a, input logic [11:0] d);
    logic [11:0] q;
    logic        s;
    u_host.access(1'b1, a, d, q, s);
    if (master_mode_i && a <= 5'h14) mdl[a] = d;
  endtask
  task automatic rd(input logic [4:0] a);
    logic [11:0] q;
    logic        s;
    u_host.access(1'b0, a, 12'h000, q, s);
    chk1(s, master_mode_i, "read drive");
    if (master_mode_i) chk12(q, exp_rd(a), "read data");
  endtask
  task automatic chk_fields();
    logic [11:0] c;
    c = mdl[ssrp_pkg::OFS_CTL1];
    chk12(ctl0_o, mdl[ssrp_pkg::OFS_CTL0], "ctl0");
    chk1(rsh_o, c[5], "holdoff enable");
    chk1(aux_o, c[6], "aux bypass");
    // Pause sits in bit 7, column low in bit 11
    chk12({7'h00, ctl_eff_o}, {7'h00, master_mode_i ?
      {c[7], c[8], c[9], c[10], c[11]} : ctl_pins_i}, "mirror");
  endtask
  task automatic build_exp();
    int k, r, c;
    exp_q.delete();
    for (k = 0; k < 2; k++) begin
      if (mdl[k * 4 + 1] == 12'h000) break;
      for (r = mdl[k * 4]; r <= mdl[k * 4 + 1]; r++)
        for (c = mdl[k * 4 + 2]; c <= mdl[k * 4 + 3]; c++)
          exp_q.push_back({!(k == 1 && r >= mdl[0] && r <= mdl[1]),
                           r[11:0], c[11:0]});
    end
  endtask
  // Runs frames behind a sync wait, then stops at a frame edge
  task automatic run_frames();
    build_exp();
    got_q.delete();
    n_aux = 0;
    wr(ssrp_pkg::OFS_CTL0, 12'h810);
    repeat (40) @(posedge clk_sys_i);
    chk1(got_q.size() == 0, 1'b1, "sync wait");
    #2 sync_pulse_i = 1'b1;
    repeat (60) @(posedge clk_sys_i);
    wr(ssrp_pkg::OFS_CTL0, 12'h000);
    n = 0;
    while (halted_o !== 1'b1 && n < 400) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk1(halted_o, 1'b1, "halt");
    if (n == 400) final_report();
    chk1(got_q.size() > 0 && got_q.size() % exp_q.size() == 0, 1'b1,
         "whole frames");
    for (i = 0; i < got_q.size(); i++) begin
      chk12(got_q[i][23:12], exp_q[i % exp_q.size()][23:12], "row");
      chk12(got_q[i][11:0], exp_q[i % exp_q.size()][11:0], "col");
      chk1(got_q[i][24], exp_q[i % exp_q.size()][24], "valid");
    end
    repeat (2) @(posedge clk_sys_i);
    chk12(12'(n_aux), mdl[ssrp_pkg::OFS_CTL1][6] ?
          12'(got_q.size() / exp_q.size()) : 12'h000, "aux slot");
    #2 sync_pulse_i = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (pix_active_o === 1'b1) got_q.push_back({pix_valid_o, row_o, col_o});
    if (aux_sel_o === 1'b1) n_aux++;
  end
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    master_mode_i = 1'b1;
    sync_pulse_i = 1'b0;
    ctl_pins_i = 5'h00;
    for (i = 0; i < 32; i++) mdl[i] = ssrp_pkg::OTHER_RST;
    mdl[ssrp_pkg::OFS_CTL0] = ssrp_pkg::CTL0_RST;
    mdl[ssrp_pkg::OFS_CTL1] = ssrp_pkg::CTL1_RST;
    repeat (16) @(posedge clk_sys_i);
    #2 rst_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk_fields();
    rd(ssrp_pkg::OFS_CTL1);
    $display("reset values done");
    wr(ssrp_pkg::OFS_CTL1, 12'hFFF);
    rd(ssrp_pkg::OFS_CTL1);
    wr(5'h1C, 12'hFFF);
    rd(5'h1C);
    for (n = 0; n < 10; n++) begin
      i = $unsigned($random(seed)) % 21;
      if (i == ssrp_pkg::OFS_CTL0) i = ssrp_pkg::OFS_CTL1;
      ctl_pins_i = $random(seed);
      wr(i[4:0], $random(seed));
      rd(i[4:0]);
      chk_fields();
    end
    $display("register access done");
    @(posedge clk_sys_i);
    #2 master_mode_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    wr(ssrp_pkg::OFS_CTL1, 12'h0A5);
    rd(ssrp_pkg::OFS_CTL1);
    chk_fields();
    @(posedge clk_sys_i);
    #2 master_mode_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    $display("slave mode done");
    wr(ssrp_pkg::OFS_CTL1, 12'h040);
    for (i = 0; i < 8; i++) wr(i[4:0], (i < 4) ? 1 + i % 2 : 2 + i - 4);
    wr(5'h06, 12'h005);
    wr(5'h07, 12'h006);
    run_frames();
    $display("two regions done");
    wr(5'h05, 12'h000);
    wr(ssrp_pkg::OFS_CTL1, 12'h020);
    chk_fields();
    run_frames();
    $display("zero row stop done");
    final_report();
  end
endmodule // ssrp_top_test
`default_nettype wire
